// ### inc/tca_pkg.sv
// Behaviour
// - host sets id_assign_flag, drives mode clocks
// - no-audio device sits last in chain
// - fields 32 bits, msb first, command first
// - ext_cmd_flag adds extended field, drops audio
// - audio channels sent unless audio_port_ctrl high; the code sends them only while CTRL_AUDIO is set
// - host sends audio for every enabled channel
// - chain_select_flag low addresses input chain
// - register ID 22:16, data 15:8
// - extended field layout, top bit reserved
// - audio 24 bits on top, zeros below
package tca_pkg;
  // register offsets on the ahb side
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_CMD = 8'h04;
  localparam logic [7:0] OFS_EXT = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0c;
  localparam logic [7:0] OFS_AUD_BASE = 8'h10;
  // control bits
  localparam int CTRL_RUN = 0;
  localparam int CTRL_AUDIO = 1;
  // status bits
  localparam int ST_LIVE = 0;
  localparam int ST_PEND = 1;
  localparam int ST_RDV = 2;
  localparam int ST_DONE = 3;
  localparam int ST_RDATA = 8;
  // command field positions
  localparam int FLD_ID_ASSIGN = 31;
  localparam int FLD_EXT = 30;
  localparam int FLD_CHAIN = 29;
  localparam int FLD_READ = 23;
  localparam int FLD_DATA_LO = 8;
  localparam int FIELD_BITS = 32;
  localparam logic [4:0] RD_FIRST_POS = 5'h10;
  localparam logic [4:0] RD_LAST_POS = 5'h17;
  // link timing: 800 ns bit clock period from a 100 ns hclk
  localparam int HCLK_NS = 100;
  localparam int BCLK_NS = 800;
  localparam int HALF_DIV = BCLK_NS / (2 * HCLK_NS);
  localparam int SYNC_PULSE_BITS = 2;
  // reset values
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  // frame progress, gray along the warm-up path
  typedef enum logic [1:0] {
    TCA_IDLE = 2'b00,
    TCA_WARM1 = 2'b01,
    TCA_WARM2 = 2'b11,
    TCA_LIVE = 2'b10
  } tca_mode_t;
  // link pins driven toward the device
  typedef struct packed {
    logic bit_clock;
    logic frame_sync;
    logic cmd_audio_in;
  } tca_link_t;
endpackage

// ### logic/tca_bclk_gen.sv
`timescale 1ns/1ps
`default_nettype none
module tca_bclk_gen #(
  parameter int HALF = tca_pkg::HALF_DIV
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic run,
  output logic bclk_ff,
  output logic fall_p_ff,
  output logic sample_p_ff
);
  logic [7:0] cnt_ff;
  wire half_end = (cnt_ff == 8'(HALF - 1));
  wire pre_end = (cnt_ff == 8'(HALF - 2));

  // divider: bit clock idles low while stopped
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_ff <= 8'h00;
      bclk_ff <= 1'b0;
    end else if (!run) begin
      cnt_ff <= 8'h00;
      bclk_ff <= 1'b0;
    end else if (half_end) begin
      cnt_ff <= 8'h00;
      bclk_ff <= ~bclk_ff;
    end else begin
      cnt_ff <= cnt_ff + 8'h01;
    end
  end

  // strobes: new bit after falling edge, sample late in high half
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fall_p_ff <= 1'b0;
      sample_p_ff <= 1'b0;
    end else begin
      fall_p_ff <= run && half_end && bclk_ff;
      sample_p_ff <= run && pre_end && bclk_ff;
    end
  end
endmodule
`default_nettype wire

// ### logic/tca_host.sv
`timescale 1ns/1ps
`default_nettype none
module tca_host #(
  parameter int FRAME_BITS = 128,
  parameter int N_CH = 2
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  output logic bit_clock,
  output logic frame_sync,
  output logic cmd_audio_in,
  input wire logic dev_read_data
);
  localparam int BW = $clog2(FRAME_BITS);
  localparam int FW = BW - 5;

  // ahb side state
  logic hreadyout_ff;
  logic hresp_ff;
  logic [31:0] hrdata_ff;
  logic wr_pend_ff;
  logic [7:0] wr_addr_ff;
  logic [31:0] ctrl_ff;
  logic [31:0] cmd_ff;
  logic [31:0] ext_ff;
  logic [23:0] aud_ff [N_CH];
  logic cmd_pend_ff;
  logic rd_valid_ff;
  logic done_ff;
  logic [7:0] rd_byte_ff;

  // link side state
  tca_pkg::tca_link_t link_ff;
  tca_pkg::tca_mode_t mode_ff;
  logic [BW-1:0] bit_cnt_ff;
  logic [31:0] frm_cmd_ff;
  logic [31:0] frm_ext_ff;
  logic sent_ff;
  logic [7:0] rd_shift_ff;
  logic rd_sync1_ff;
  logic rd_sync2_ff;

  // divider outputs
  logic bclk_ff;
  logic fall_p;
  logic sample_p;

  // audio register address match, used by the read mux only
  function automatic logic is_aud(input logic [7:0] a, output int idx);
    idx = 0;
    is_aud = 1'b0;
    for (int i = 0; i < N_CH; i++) begin
      if (a == 8'(tca_pkg::OFS_AUD_BASE + 4 * i)) begin
        is_aud = 1'b1;
        idx = i;
      end
    end
  endfunction

  // bus decode
  wire addr_ok = (haddr[31:8] == 24'h00_0000);
  wire take = hsel && hready && htrans[1];
  wire take_rd = take && !hwrite;
  wire take_wr = take && hwrite;
  wire [7:0] ra = haddr[7:0];
  wire wr_ctrl = wr_pend_ff && (wr_addr_ff == tca_pkg::OFS_CTRL);
  wire wr_cmd = wr_pend_ff && (wr_addr_ff == tca_pkg::OFS_CMD);
  wire wr_ext = wr_pend_ff && (wr_addr_ff == tca_pkg::OFS_EXT);
  wire wr_stat = wr_pend_ff && (wr_addr_ff == tca_pkg::OFS_STATUS);
  wire run = ctrl_ff[tca_pkg::CTRL_RUN];
  wire audio_en = ctrl_ff[tca_pkg::CTRL_AUDIO];
  wire live = (mode_ff == tca_pkg::TCA_LIVE);

  // status word as software sees it
  wire [31:0] status_word = {16'h0000, rd_byte_ff, 4'h0, done_ff, rd_valid_ff,
                             cmd_pend_ff, live};

  // read mux; unmapped offsets read zero
  logic [31:0] rd_mux;
  always_comb begin
    int ai;
    ai = 0;
    rd_mux = 32'h0000_0000;
    if (!addr_ok) begin
      rd_mux = 32'h0000_0000;
    end else if (ra == tca_pkg::OFS_CTRL) begin
      rd_mux = ctrl_ff;
    end else if (ra == tca_pkg::OFS_CMD) begin
      rd_mux = cmd_ff;
    end else if (ra == tca_pkg::OFS_EXT) begin
      rd_mux = ext_ff;
    end else if (ra == tca_pkg::OFS_STATUS) begin
      rd_mux = status_word;
    end else if (is_aud(ra, ai)) begin
      rd_mux = {8'h00, aud_ff[ai]};
    end
  end

  // address phase capture; slave never stalls and always answers okay
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout_ff <= 1'b1;
      hresp_ff <= 1'b0;
      hrdata_ff <= tca_pkg::RST_WORD;
      wr_pend_ff <= 1'b0;
      wr_addr_ff <= 8'h00;
    end else begin
      hreadyout_ff <= 1'b1;
      hresp_ff <= 1'b0;
      wr_pend_ff <= take_wr && addr_ok;
      wr_addr_ff <= ra;
      if (take_rd) begin
        hrdata_ff <= rd_mux;
      end
    end
  end

  // plain control registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_ff <= tca_pkg::RST_WORD;
      cmd_ff <= tca_pkg::RST_WORD;
      ext_ff <= tca_pkg::RST_WORD;
    end else begin
      if (wr_ctrl) begin
        ctrl_ff <= {30'h0, hwdata[tca_pkg::CTRL_AUDIO], hwdata[tca_pkg::CTRL_RUN]};
      end
      if (wr_cmd) begin
        cmd_ff <= hwdata;
      end
      if (wr_ext) begin
        ext_ff <= hwdata;
      end
    end
  end

  // audio sample registers, one word per channel
  for (genvar g = 0; g < N_CH; g++) begin : g_aud
    wire wr_this = wr_pend_ff && (wr_addr_ff == 8'(tca_pkg::OFS_AUD_BASE + 4 * g));
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        aud_ff[g] <= 24'h00_0000;
      end else if (wr_this) begin
        aud_ff[g] <= hwdata[23:0];
      end
    end
  end

  // bit clock divider and bit strobes
  tca_bclk_gen #(
    .HALF(tca_pkg::HALF_DIV)
  ) u_bclk (
    .hclk(hclk),
    .hresetn(hresetn),
    .run(run),
    .bclk_ff(bclk_ff),
    .fall_p_ff(fall_p),
    .sample_p_ff(sample_p)
  );

  // frame position
  wire last_bit = (bit_cnt_ff == BW'(FRAME_BITS - 1));
  wire [BW-1:0] nxt_bit_cnt = last_bit ? '0 : bit_cnt_ff + BW'(1);
  wire frame_start = fall_p && last_bit;
  wire [FW-1:0] fld = bit_cnt_ff[BW-1:5];
  wire [4:0] pos = bit_cnt_ff[4:0];
  wire [FW-1:0] nxt_fld = nxt_bit_cnt[BW-1:5];
  wire [4:0] nxt_pos = nxt_bit_cnt[4:0];

  // command words as placed on the wire
  wire id_req = cmd_ff[tca_pkg::FLD_ID_ASSIGN];
  wire [31:0] id_word = {1'b1, 31'h0000_0000};
  wire [31:0] cmd_word = {1'b0, cmd_ff[tca_pkg::FLD_EXT], 1'b0,
                          cmd_ff[28:tca_pkg::FLD_DATA_LO], 8'h00};
  wire [31:0] ext_word = {1'b0, ext_ff[tca_pkg::FLD_EXT], 1'b0,
                          ext_ff[28:tca_pkg::FLD_DATA_LO], 8'h00};
  // the frame after the two warm-up frames may already carry a command
  wire cmd_ok = live || (mode_ff == tca_pkg::TCA_WARM2);
  wire send_cmd = cmd_ok && cmd_pend_ff;
  wire [31:0] nxt_frm_cmd = !send_cmd ? tca_pkg::RST_WORD : (id_req ? id_word : cmd_word);

  // word for a given field of the current frame
  function automatic logic [31:0] field_word(input logic [FW-1:0] f);
    int ch;
    ch = int'(f) - 1;
    field_word = 32'h0000_0000;
    if (f == '0) begin
      field_word = frm_cmd_ff;
    end else if (frm_cmd_ff[tca_pkg::FLD_EXT]) begin
      if (f == FW'(1)) begin
        field_word = frm_ext_ff;
      end
    end else if (audio_en && ch >= 0 && ch < N_CH) begin
      field_word = {aud_ff[ch], 8'h00};
    end
  endfunction

  wire [31:0] nxt_word = field_word(nxt_fld);
  wire nxt_data = nxt_word[5'd31 - nxt_pos];
  wire nxt_sync = (nxt_bit_cnt < BW'(tca_pkg::SYNC_PULSE_BITS));

  // warm-up: two pulse-form frames before commands go out
  tca_pkg::tca_mode_t nxt_mode;
  always_comb begin
    nxt_mode = mode_ff;
    case (mode_ff)
      tca_pkg::TCA_IDLE: nxt_mode = tca_pkg::TCA_WARM1;
      tca_pkg::TCA_WARM1: nxt_mode = tca_pkg::TCA_WARM2;
      tca_pkg::TCA_WARM2: nxt_mode = tca_pkg::TCA_LIVE;
      default: nxt_mode = tca_pkg::TCA_LIVE;
    endcase
  end

  // frame sequencing on the host clock
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mode_ff <= tca_pkg::TCA_IDLE;
      bit_cnt_ff <= BW'(FRAME_BITS - 1);
      frm_cmd_ff <= tca_pkg::RST_WORD;
      frm_ext_ff <= tca_pkg::RST_WORD;
      sent_ff <= 1'b0;
    end else if (!run) begin
      mode_ff <= tca_pkg::TCA_IDLE;
      bit_cnt_ff <= BW'(FRAME_BITS - 1);
      frm_cmd_ff <= tca_pkg::RST_WORD;
      sent_ff <= 1'b0;
    end else if (fall_p) begin
      bit_cnt_ff <= nxt_bit_cnt;
      if (frame_start) begin
        mode_ff <= nxt_mode;
        frm_cmd_ff <= nxt_frm_cmd;
        frm_ext_ff <= ext_word;
        sent_ff <= send_cmd;
      end
    end
  end

  // pins change one hclk after the bit clock falls
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      link_ff <= '0;
    end else if (!run) begin
      link_ff <= '0;
    end else begin
      link_ff.bit_clock <= bclk_ff;
      if (fall_p) begin
        link_ff.frame_sync <= nxt_sync;
        link_ff.cmd_audio_in <= frame_start ? nxt_frm_cmd[31] : nxt_data;
      end
    end
  end

  // read data from the device crosses in through two flops
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rd_sync1_ff <= 1'b0;
      rd_sync2_ff <= 1'b0;
    end else begin
      rd_sync1_ff <= dev_read_data;
      rd_sync2_ff <= rd_sync1_ff;
    end
  end

  // capture read byte during data bits of the command field
  wire frm_read = frm_cmd_ff[tca_pkg::FLD_READ] && !frm_cmd_ff[tca_pkg::FLD_ID_ASSIGN];
  wire rd_bit = sample_p && frm_read && (fld == '0) &&
                (pos >= tca_pkg::RD_FIRST_POS) && (pos <= tca_pkg::RD_LAST_POS);
  wire rd_end = rd_bit && (pos == tca_pkg::RD_LAST_POS);
  wire [7:0] nxt_rd_shift = {rd_shift_ff[6:0], rd_sync2_ff};

  // sticky flags: hardware set wins over software clear
  wire clr_rdv = wr_stat && hwdata[tca_pkg::ST_RDV];
  wire clr_done = wr_stat && hwdata[tca_pkg::ST_DONE];
  wire set_done = run && frame_start && sent_ff;
  wire take_cmd = run && frame_start && send_cmd;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rd_shift_ff <= 8'h00;
      rd_byte_ff <= 8'h00;
      rd_valid_ff <= 1'b0;
      done_ff <= 1'b0;
      cmd_pend_ff <= 1'b0;
    end else begin
      if (rd_bit) begin
        rd_shift_ff <= nxt_rd_shift;
      end
      if (rd_end) begin
        rd_byte_ff <= nxt_rd_shift;
      end
      rd_valid_ff <= rd_end || (rd_valid_ff && !clr_rdv);
      done_ff <= set_done || (done_ff && !clr_done);
      cmd_pend_ff <= wr_cmd || (cmd_pend_ff && !take_cmd);
    end
  end

  // outputs straight from flops
  assign hrdata = hrdata_ff;
  assign hreadyout = hreadyout_ff;
  assign hresp = hresp_ff;
  assign bit_clock = link_ff.bit_clock;
  assign frame_sync = link_ff.frame_sync;
  assign cmd_audio_in = link_ff.cmd_audio_in;

  // hsize is always a word here
  wire unused_ok = &{1'b0, hsize};
endmodule
`default_nettype wire

// ### bench/tca_host_checker.sv
`timescale 1ns/1ps
`default_nettype none
module tca_host_checker #(
  parameter int FRAME_BITS = 128
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic bit_clock,
  input wire logic frame_sync,
  input wire logic cmd_audio_in
);
  logic [12:0] cnt_ff;
  logic fs_q_ff;
  logic seen_ff;
  wire logic fs_rise;
  wire logic [12:0] nxt_cnt;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // cycles since the last frame start
  assign fs_rise = frame_sync & ~fs_q_ff;
  assign nxt_cnt = fs_rise ? 13'h1 : cnt_ff + 13'h1;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_ff <= 13'h0;
      fs_q_ff <= 1'b0;
      seen_ff <= 1'b0;
    end else begin
      cnt_ff <= nxt_cnt;
      fs_q_ff <= frame_sync;
      seen_ff <= seen_ff | fs_rise;
    end
  end
  chk_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus not ready or not okay");
  chk_sync_len: assert property ($rose(frame_sync) |-> frame_sync[*8] ##1 frame_sync[*8] ##1 !frame_sync)
    else $error("frame sync pulse length wrong");
  chk_data_launch: assert property ($changed(cmd_audio_in) || $changed(frame_sync) |-> $fell(bit_clock))
    else $error("link data not launched after falling clock");
  chk_bclk_half: assert property ($rose(bit_clock) |-> bit_clock[*4] ##1 (!bit_clock)[*4] ##1 bit_clock)
    else $error("link clock halves wrong");
  chk_frame_len: assert property (fs_rise && seen_ff |-> cnt_ff == FRAME_BITS * 8)
    else $error("frame length wrong");
  chk_chain_low: assert property ($rose(frame_sync) |-> ##16 (!cmd_audio_in)[*8])
    else $error("chain select bit not low");
  chk_id_only: assert property ($rose(frame_sync) && cmd_audio_in |-> ##8 (!cmd_audio_in)[*8] ##1 (!cmd_audio_in)[*8] ##1 (!cmd_audio_in)[*8])
    else $error("id frame carries other bits");
  chk_low_byte: assert property ($rose(frame_sync) |-> ##192 (!cmd_audio_in)[*8] ##1 (!cmd_audio_in)[*8])
    else $error("command low byte not zero");
endmodule
bind tca_host tca_host_checker #(.FRAME_BITS(FRAME_BITS)) i_chk (.hclk(hclk), .hresetn(hresetn),
  .hreadyout(hreadyout), .hresp(hresp), .bit_clock(bit_clock), .frame_sync(frame_sync),
  .cmd_audio_in(cmd_audio_in));
`default_nettype wire

// ### bench/tca_dev_model.sv
`timescale 1ns/1ps
`default_nettype none
module tca_dev_model (
  input wire logic bit_clock,
  input wire logic frame_sync,
  input wire logic cmd_audio_in,
  output logic dev_read_data
);
  logic [31:0] sr = 32'h0;
  logic [31:0] fld [4];
  logic [7:0] regs [128];
  logic [6:0] ra = 7'h0;
  logic fs_q = 1'b0;
  logic own = 1'b0;
  logic rdc = 1'b0;
  int pos = 0;
  int frm = -1;
  int cf = 99;
  initial dev_read_data = 1'b0;
  initial foreach (regs[k]) regs[k] = 8'h00;
  // shift in on rising clock, decode each command field
  always @(posedge bit_clock) begin
    sr = {sr[30:0], cmd_audio_in};
    pos = (frame_sync && !fs_q) ? 0 : pos + 1;
    if (pos == 0) frm++;
    fs_q = frame_sync;
    if (pos % 32 == 31 && pos < 128) fld[pos / 32] = sr;
    if (pos == 31 && sr != 0 && frm < cf) cf = frm;
    if (pos == 31 && sr[31]) own = 1'b1;
    else if (pos == 31 && !sr[29] && !sr[23] && (sr[28:24] == 5'h1f || own && sr[28:24] == 5'h01))
      regs[sr[22:16]] = sr[15:8];
    if (pos == 14) rdc = own && !sr[14] && !sr[12] && sr[11:7] == 5'h01 && sr[6];
    if (pos == 15) ra = sr[6:0];
  end
  // read byte on falling edges, one bit early; a released line wanders
  always @(negedge bit_clock) begin
    if (rdc && pos == 14) dev_read_data <= 1'b0;
    else if (rdc && pos >= 15 && pos <= 22) dev_read_data <= regs[ra][22 - pos];
    else dev_read_data <= ~dev_read_data;
  end
endmodule
`default_nettype wire

// ### bench/tca_host_test.sv
`timescale 1ns/1ps
`default_nettype none
module tca_host_test;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  wire logic [31:0] hrdata;
  wire logic hreadyout, bit_clock, frame_sync, cmd_audio_in, dev_read_data;
  int errors = 0;
  int tests_run = 0;
  logic [31:0] rd, st, c, a0, a1;
  logic [6:0] r;
  logic [7:0] d, ex;
  always #50 hclk = ~hclk;
  tca_host i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(), .bit_clock(bit_clock), .frame_sync(frame_sync),
    .cmd_audio_in(cmd_audio_in), .dev_read_data(dev_read_data));
  tca_dev_model i_dev (.bit_clock(bit_clock), .frame_sync(frame_sync),
    .cmd_audio_in(cmd_audio_in), .dev_read_data(dev_read_data));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic test_done();
    $display("checks %0d errors %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // one single word transfer, address phase then data phase
  task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] dw);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= wr;
    htrans <= 2'h2;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= dw;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
    hsel <= 1'b0;
  endtask
  // post a command, poll for done, keep status, clear flags
  task automatic send(input logic [31:0] cw);
    int n;
    n = 0;
    ahb(1'b1, 32'(tca_pkg::OFS_CMD), cw);
    rd = 32'h0;
    while (rd[tca_pkg::ST_DONE] !== 1'b1 && n < 3000) begin
      ahb(1'b0, 32'(tca_pkg::OFS_STATUS), 32'h0);
      n++;
    end
    check(32'(n < 3000), 32'h1);
    st = rd;
    ahb(1'b1, 32'(tca_pkg::OFS_STATUS), 32'hc);
  endtask
  // command word as it should appear on the link
  function automatic logic [31:0] sent(input logic [31:0] cw);
    if (cw[31]) return 32'h8000_0000;
    return {1'b0, cw[30], 1'b0, cw[28:8], 8'h00};
  endfunction
  function automatic logic [31:0] cmd(input logic rw, input logic [4:0] id,
    input logic [6:0] rg, input logic [7:0] dv);
    return {3'b001, id, rw, rg, dv, 8'hff};
  endfunction
  // main sequence
  initial begin
    void'($urandom(54));
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    ahb(1'b0, 32'(tca_pkg::OFS_STATUS), 32'h0);
    check(rd, tca_pkg::RST_WORD);
    ahb(1'b1, 32'h100, 32'h3);
    ahb(1'b0, 32'h100, 32'h0);
    check(rd, 32'h0);
    ahb(1'b0, 32'(tca_pkg::OFS_CTRL), 32'h0);
    check(rd, 32'h0);
    a0 = $urandom() & 32'hff_ffff;
    a1 = $urandom() & 32'hff_ffff;
    ahb(1'b1, 32'(tca_pkg::OFS_AUD_BASE), a0);
    ahb(1'b1, 32'(tca_pkg::OFS_AUD_BASE) + 32'h4, a1);
    ahb(1'b1, 32'(tca_pkg::OFS_CTRL), 32'h3);
    send(32'hbfff_ffff);
    check(i_dev.fld[0], 32'h8000_0000);
    check(32'(i_dev.cf), 32'h2);
    check(i_dev.fld[1], {a0[23:0], 8'h00});
    check(i_dev.fld[2], {a1[23:0], 8'h00});
    check(i_dev.fld[3], 32'h0);
    for (int i = 0; i < 4; i++) begin
      if (i != 2) r = 7'($urandom());
      d = 8'($urandom());
      if (i != 2) ex = d;
      c = cmd(1'b0, (i == 3) ? 5'h1f : (i == 2) ? 5'h00 : 5'h01, r, d);
      send(c);
      check(i_dev.fld[0], sent(c));
      send(cmd(1'b1, 5'h01, r, 8'h00));
      check(st & 32'hff04, {16'h0, ex, 8'h04});
    end
    c = $urandom() & 32'h7fff_ffff;
    ahb(1'b1, 32'(tca_pkg::OFS_EXT), c);
    send(cmd(1'b0, 5'h01, 7'h13, 8'h55) | 32'h4000_0000);
    check(i_dev.fld[1], sent(c));
    check(i_dev.fld[2], 32'h0);
    test_done();
  end
  // cut a hang short
  initial begin
    repeat (60000) @(posedge hclk);
    errors++;
    test_done();
  end
endmodule
`default_nettype wire
